// *** rtl/reset_strap_capture_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef RESET_STRAP_CAPTURE_MAP_SVH
`define RESET_STRAP_CAPTURE_MAP_SVH

// Register byte offsets
`define RSC_ADDR_CLK_CTRL 8'h00
`define RSC_ADDR_STRAPS 8'h04
`define RSC_ADDR_CONTROL 8'h08
`define RSC_ADDR_IRQ_STATUS 8'h0C
`define RSC_ADDR_IRQ_ENABLE 8'h10
`define RSC_ADDR_IRQ_CLEAR 8'h14

// Field positions
`define RSC_CLK_DIV_LSB 0
`define RSC_CLK_BYPASS_BIT 3
`define RSC_STRAP_CFG_LSB 0
`define RSC_STRAP_DEBUG_BIT 4
`define RSC_STRAP_BREAK_BIT 5
`define RSC_CTRL_SW_DRIVE_BIT 0

// Reset values
`define RSC_CONTROL_RESET 1'h0
`define RSC_IRQ_ENABLE_RESET 4'h0
`define RSC_IRQ_STATUS_RESET 4'h0
`define RSC_CFG_RESET 4'h0

// Divider code that is reserved together with bypass
`define RSC_RESERVED_DIVIDER 3'h0

// Timing: clock period and reset line drive time
`define RSC_CLK_PERIOD_PS 4000
`define RSC_DRIVE_TIME_NS 4000
`define RSC_DRIVE_CYCLES ((`RSC_DRIVE_TIME_NS * 1000) / `RSC_CLK_PERIOD_PS)
`define RSC_TIMER_W 10

`endif

// *** rtl/reset_strap_capture_pkg.sv ***
// Types shared by the reset and strap capture block
package reset_strap_capture_pkg;

    // Straps caught at power-on reset
    typedef struct packed {
        logic bypass;
        logic [2:0] divider;
        logic debug_n;
        logic break_n;
    } strap_t;

    // Sticky event bits, bit 3 first
    typedef struct packed {
        logic reserved;
        logic line;
        logic debug;
        logic nmi;
    } irq_bits_t;

    // Reset line driver states
    typedef enum logic [1:0] {
        LINE_IDLE = 2'b00,
        LINE_DRIVE = 2'b01,
        LINE_WAIT = 2'b10
    } line_state_t;

endpackage

// *** rtl/reset_pulse_timer.sv ***
// Down-counter that times one reset line pulse
`timescale 1ns/1ps
module reset_pulse_timer #(
    parameter int unsigned WIDTH = 10,
    parameter logic [WIDTH-1:0] COUNT = 10'h3E8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Load on start, then count down to zero
    always_comb begin
        count_next = count_reg;
        if (start_i) begin
            count_next = COUNT;
        end else if (count_reg != '0) begin
            count_next = count_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy_o = (count_reg != '0);
    assign done_o = (count_reg == WIDTH'(1));

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_timer_length: assert property (@(posedge clk_i) disable iff (!resetn_i)
        start_i |=> (count_reg == COUNT))
        else $error("Timer did not load its full count");

endmodule

// *** rtl/reset_strap_capture.sv ***
// Power-on strap capture, reset line handling and debug pin logic
// Overview of operation
// - Clock-select straps at power-on set loop divider
// - Captured divider straps readable in clock control
// - Bypass strap latched at power-on, high skips loop
// - Test reset low disables scan module
// - Low debug strap at power-on enables debug
// - Low break request halts when debug enabled
// - Break indication low on debug event
// - Falling edge on NMI raises trap request
// - Low reset line resets chip synchronously
// - Own resets drive reset line for fixed time
// - Software reset drives line only when enabled
// - Power-on reset acts asynchronously, by level
// - Boot option taken from config straps
`timescale 1ns/1ps
`include "reset_strap_capture_map.svh"
module reset_strap_capture (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic WR_EN_I,
    input wire logic RD_EN_I,
    output logic [31:0] RD_DATA_O,
    output logic IRQ_O,
    // Straps
    input wire logic [2:0] LOOP_DIVIDER_STRAP_I,
    input wire logic BYPASS_STRAP_I,
    input wire logic DEBUG_ENABLE_STRAP_N_I,
    input wire logic [3:0] CONFIG_STRAP_I,
    output logic [2:0] LOOP_DIVIDER_O,
    output logic BYPASS_O,
    output logic [5:0] BOOT_CONFIG_O,
    // Debug and interrupt pins
    input wire logic BREAK_REQUEST_N_I,
    input wire logic DEBUG_EVENT_I,
    input wire logic NMI_N_I,
    output logic ON_CHIP_DEBUG_SUPPORT_O,
    output logic HALT_REQ_O,
    output logic BREAK_INDICATION_N_O,
    output logic NMI_TRAP_O,
    // Test port reset gating
    input wire logic TEST_RESET_N_I,
    output logic SCAN_RESET_N_O,
    output logic SCAN_ENABLE_O,
    // Reset sources and the open-drain reset line
    input wire logic WATCHDOG_RESET_I,
    input wire logic WAKEUP_RESET_I,
    input wire logic SW_RESET_I,
    input wire logic HARDWARE_RESET_LINE_N_I,
    output logic HARDWARE_RESET_LINE_N_O,
    output logic HARDWARE_RESET_LINE_N_OE_O,
    output logic CHIP_RESET_O
);

    ////////////////////////////////////////////////////////////////////////
    // Power-on release detection
    // RESETN_I is the power-on reset; every flop below except the strap captures is reset by it
    logic por_meta_reg, por_meta_next;
    logic por_done_reg, por_done_next;
    logic por_seen_reg, por_seen_next;
    logic por_release;

    // Two-flop release sync; the second stage and the third flop por_seen_reg behind it are looked at
    always_comb begin
        por_meta_next = 1'b1;
        por_done_next = por_meta_reg;
        por_seen_next = por_done_reg;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            por_meta_reg <= 1'b0;
            por_done_reg <= 1'b0;
            por_seen_reg <= 1'b0;
        end else begin
            por_meta_reg <= por_meta_next;
            por_done_reg <= por_done_next;
            por_seen_reg <= por_seen_next;
        end
    end

    assign por_release = por_done_reg && !por_seen_reg;

    ////////////////////////////////////////////////////////////////////////
    // Strap capture
    // No async reset here: the straps are sampled on every clock while
    // power-on reset holds, then frozen until the next power-on
    reset_strap_capture_pkg::strap_t strap_reg, strap_next;

    always_comb begin
        strap_next = strap_reg;
        if (!por_done_reg) begin
            strap_next.divider = LOOP_DIVIDER_STRAP_I;
            strap_next.bypass = BYPASS_STRAP_I;
            strap_next.debug_n = DEBUG_ENABLE_STRAP_N_I;
            strap_next.break_n = BREAK_REQUEST_N_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        strap_reg <= strap_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset line driver
    reset_strap_capture_pkg::line_state_t state_reg, state_next;
    logic chip_reset_reg, chip_reset_next;
    logic [3:0] cfg_reg, cfg_next;
    logic sw_drive_reg, sw_drive_next;
    logic trigger, timer_start, timer_busy, timer_done, line_ext_low;

    // Line low while we are idle means someone else pulled it
    assign line_ext_low = !HARDWARE_RESET_LINE_N_I &&
                          (state_reg == reset_strap_capture_pkg::LINE_IDLE);
    assign trigger = por_release || WATCHDOG_RESET_I || WAKEUP_RESET_I ||
                     line_ext_low || (SW_RESET_I && sw_drive_reg);

    always_comb begin
        state_next = state_reg;
        timer_start = 1'b0;
        case (state_reg)
            reset_strap_capture_pkg::LINE_IDLE: begin
                if (trigger) begin
                    state_next = reset_strap_capture_pkg::LINE_DRIVE;
                    timer_start = 1'b1;
                end
            end
            reset_strap_capture_pkg::LINE_DRIVE: begin
                if (timer_done) begin
                    state_next = reset_strap_capture_pkg::LINE_WAIT;
                end
            end
            reset_strap_capture_pkg::LINE_WAIT: begin
                // Outside pullers may hold it longer; wait for release
                if (HARDWARE_RESET_LINE_N_I) begin
                    state_next = reset_strap_capture_pkg::LINE_IDLE;
                end
            end
            default: begin
                state_next = reset_strap_capture_pkg::LINE_IDLE;
            end
        endcase
    end

    // Chip reset follows the line; config straps read during it
    always_comb begin
        chip_reset_next = !HARDWARE_RESET_LINE_N_I;
        cfg_next = cfg_reg;
        if (chip_reset_reg || !por_done_reg) begin
            cfg_next = CONFIG_STRAP_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= reset_strap_capture_pkg::LINE_IDLE;
            chip_reset_reg <= 1'b1;
            cfg_reg <= `RSC_CFG_RESET;
        end else begin
            state_reg <= state_next;
            chip_reset_reg <= chip_reset_next;
            cfg_reg <= cfg_next;
        end
    end

    reset_pulse_timer #(
        .WIDTH(`RSC_TIMER_W),
        .COUNT(`RSC_TIMER_W'(`RSC_DRIVE_CYCLES))
    ) reset_pulse_timer_inst (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .start_i(timer_start),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    // Open drain: data is always low, only the enable moves
    assign HARDWARE_RESET_LINE_N_O = 1'b0;
    assign HARDWARE_RESET_LINE_N_OE_O =
        (state_reg == reset_strap_capture_pkg::LINE_DRIVE) && timer_busy;
    assign CHIP_RESET_O = chip_reset_reg;

    ////////////////////////////////////////////////////////////////////////
    // Debug, NMI and scan pins
    logic halt_reg, halt_next;
    logic brk_n_reg, brk_n_next;
    logic nmi_prev_reg, nmi_prev_next;
    logic trap_reg, trap_next;
    logic scan_en_reg, scan_en_next;
    logic debug_on;

    assign debug_on = !strap_reg.debug_n;

    always_comb begin
        halt_next = debug_on && !BREAK_REQUEST_N_I;
        brk_n_next = !DEBUG_EVENT_I;
        nmi_prev_next = NMI_N_I;
        trap_next = nmi_prev_reg && !NMI_N_I;
        scan_en_next = TEST_RESET_N_I;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            halt_reg <= 1'b0;
            brk_n_reg <= 1'b1;
            nmi_prev_reg <= 1'b1;
            trap_reg <= 1'b0;
            scan_en_reg <= 1'b0;
        end else begin
            halt_reg <= halt_next;
            brk_n_reg <= brk_n_next;
            nmi_prev_reg <= nmi_prev_next;
            trap_reg <= trap_next;
            scan_en_reg <= scan_en_next;
        end
    end

    assign ON_CHIP_DEBUG_SUPPORT_O = debug_on && por_done_reg;
    assign HALT_REQ_O = halt_reg;
    assign BREAK_INDICATION_N_O = brk_n_reg;
    assign NMI_TRAP_O = trap_reg;
    assign SCAN_ENABLE_O = scan_en_reg;
    assign SCAN_RESET_N_O = scan_en_reg;
    assign LOOP_DIVIDER_O = strap_reg.divider;
    assign BYPASS_O = strap_reg.bypass;
    assign BOOT_CONFIG_O = {strap_reg.break_n, strap_reg.debug_n, cfg_reg};

    ////////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    reset_strap_capture_pkg::irq_bits_t irq_stat_reg, irq_stat_next;
    reset_strap_capture_pkg::irq_bits_t irq_en_reg, irq_en_next;
    reset_strap_capture_pkg::irq_bits_t irq_set, irq_clr;
    logic [31:0] rd_data_reg, rd_data_next;
    logic [31:0] clk_ctrl_word, strap_word;

    // Reserved strap mix is only flagged; the board must avoid it
    always_comb begin
        irq_set.nmi = trap_next;
        irq_set.debug = DEBUG_EVENT_I;
        irq_set.line = line_ext_low;
        irq_set.reserved = por_release && strap_reg.bypass &&
                           (strap_reg.divider == `RSC_RESERVED_DIVIDER);
    end

    assign irq_clr = (WR_EN_I && ADDR_I == `RSC_ADDR_IRQ_CLEAR) ?
                     WR_DATA_I[3:0] : 4'h0;

    always_comb begin
        clk_ctrl_word = 32'h0;
        clk_ctrl_word[`RSC_CLK_DIV_LSB +: 3] = strap_reg.divider;
        clk_ctrl_word[`RSC_CLK_BYPASS_BIT] = strap_reg.bypass;
        strap_word = 32'h0;
        strap_word[`RSC_STRAP_CFG_LSB +: 4] = cfg_reg;
        strap_word[`RSC_STRAP_DEBUG_BIT] = strap_reg.debug_n;
        strap_word[`RSC_STRAP_BREAK_BIT] = strap_reg.break_n;
    end

    // Set wins over a clear landing in the same cycle
    always_comb begin
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
        irq_en_next = irq_en_reg;
        sw_drive_next = sw_drive_reg;
        if (WR_EN_I && ADDR_I == `RSC_ADDR_IRQ_ENABLE) begin
            irq_en_next = WR_DATA_I[3:0];
        end
        if (WR_EN_I && ADDR_I == `RSC_ADDR_CONTROL) begin
            sw_drive_next = WR_DATA_I[`RSC_CTRL_SW_DRIVE_BIT];
        end
        rd_data_next = 32'h0;
        if (RD_EN_I) begin
            case (ADDR_I)
                `RSC_ADDR_CLK_CTRL: rd_data_next = clk_ctrl_word;
                `RSC_ADDR_STRAPS: rd_data_next = strap_word;
                `RSC_ADDR_CONTROL: rd_data_next = {31'h0, sw_drive_reg};
                `RSC_ADDR_IRQ_STATUS: rd_data_next = {28'h0, irq_stat_reg};
                `RSC_ADDR_IRQ_ENABLE: rd_data_next = {28'h0, irq_en_reg};
                default: rd_data_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_stat_reg <= `RSC_IRQ_STATUS_RESET;
            irq_en_reg <= `RSC_IRQ_ENABLE_RESET;
            sw_drive_reg <= `RSC_CONTROL_RESET;
            rd_data_reg <= 32'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            sw_drive_reg <= sw_drive_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign RD_DATA_O = rd_data_reg;
    assign IRQ_O = |(irq_stat_reg & irq_en_reg);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_divider_sample: assert property (
        !por_done_reg |=> LOOP_DIVIDER_O == $past(LOOP_DIVIDER_STRAP_I))
        else $error("Divider strap not sampled in power-on reset");
    a_clock_readback: assert property (
        RD_EN_I && ADDR_I == `RSC_ADDR_CLK_CTRL |=>
        RD_DATA_O[3:0] == {BYPASS_O, LOOP_DIVIDER_O})
        else $error("Clock control readback wrong");
    a_bypass_sample: assert property (
        !por_done_reg |=> BYPASS_O == $past(BYPASS_STRAP_I))
        else $error("Bypass strap not sampled in power-on reset");
    a_scan_gate: assert property (
        !TEST_RESET_N_I |=> !SCAN_ENABLE_O && !SCAN_RESET_N_O)
        else $error("Scan module not held by test reset");
    a_debug_enable: assert property (
        $rose(por_done_reg) |-> ON_CHIP_DEBUG_SUPPORT_O ==
        !$past(DEBUG_ENABLE_STRAP_N_I))
        else $error("Debug enable disagrees with strap");
    a_halt_request: assert property (
        ON_CHIP_DEBUG_SUPPORT_O && !BREAK_REQUEST_N_I |=> HALT_REQ_O)
        else $error("Break request did not halt");
    a_break_out: assert property (
        DEBUG_EVENT_I |=> !BREAK_INDICATION_N_O ##0 IRQ_O || !irq_en_reg.debug)
        else $error("Debug event not shown on break output");
    a_nmi_edge: assert property (
        $fell(NMI_N_I) |=> NMI_TRAP_O ##1 !NMI_TRAP_O || $fell(NMI_N_I))
        else $error("NMI edge not turned into one trap pulse");
    a_nmi_level: assert property (
        $stable(NMI_N_I) |=> !NMI_TRAP_O)
        else $error("NMI trap raised without an edge");
    a_line_reset: assert property (
        !HARDWARE_RESET_LINE_N_I |=> CHIP_RESET_O)
        else $error("Low reset line did not reset the chip");
    a_watchdog_drive: assert property (
        WATCHDOG_RESET_I && state_reg == reset_strap_capture_pkg::LINE_IDLE
        |=> HARDWARE_RESET_LINE_N_OE_O [*8])
        else $error("Watchdog reset did not drive the line");
    a_sw_no_drive: assert property (
        state_reg == reset_strap_capture_pkg::LINE_IDLE && SW_RESET_I &&
        !sw_drive_reg && !WATCHDOG_RESET_I && !WAKEUP_RESET_I &&
        HARDWARE_RESET_LINE_N_I && !por_release
        |=> !HARDWARE_RESET_LINE_N_OE_O)
        else $error("Software reset drove the line while disabled");
    a_boot_config: assert property (
        chip_reset_reg |=> BOOT_CONFIG_O[3:0] == $past(CONFIG_STRAP_I))
        else $error("Config straps not taken during hardware reset");
    a_strap_frozen: assert property (
        por_done_reg && $past(por_done_reg) |-> $stable(strap_reg))
        else $error("Captured straps changed after power-on");

endmodule

// *** verif/board_reset_model.sv ***
// Board-side model: reset line pull-up, external reset pulse and straps
`timescale 1ns/1ps
module board_reset_model #(
    parameter int MIN_PULL = 8
) (
    input wire logic clk_i,
    input wire logic pull_req_i,
    input wire logic line_oe_i,
    input wire logic line_drive_i,
    input wire logic [2:0] divider_i,
    input wire logic bypass_i,
    output logic bypass_o,
    output logic line_n_o
);
    int pull_cnt = 0;

    ////////////////////////////////////////////////////////////////////////
    // A request starts a pulse that is never cut short of its minimum
    always @(posedge clk_i) begin
        if (pull_req_i === 1'b1 && pull_cnt == 0) begin
            pull_cnt <= MIN_PULL;
        end else if (pull_cnt != 0) begin
            pull_cnt <= pull_cnt - 1;
        end
    end

    // Wired-and with pull-up: released line reads high, never the old value
    assign line_n_o = (pull_cnt != 0 || (line_oe_i === 1'b1 &&
        line_drive_i === 1'b0)) ? 1'b0 : 1'b1;

    // The board never presents bypass with divider code zero
    assign bypass_o = (divider_i == 3'h0) ? 1'b0 : bypass_i;
endmodule

// *** verif/reset_strap_capture_bench.sv ***
// Directed testbench for the reset and strap capture block
`timescale 1ns/1ps
`include "reset_strap_capture_map.svh"
module reset_strap_capture_bench;
    logic clk, resetn, wr_en, rd_en, irq, bypass_req, bypass, debug_n;
    logic [7:0] addr;
    logic [31:0] wdata, rd_data;
    logic [2:0] divider, div_out;
    logic [3:0] cfg;
    logic [5:0] boot_cfg;
    logic brk_n, dbg_event, nmi_n, on_chip_debug_support, halt, brk_ind_n, nmi_trap;
    logic test_rst_n, scan_rst_n, scan_en, wd, wake, sw, pull;
    logic line_n, line_drv, oe, chip_rst, byp_out;
    int num_errors = 0;
    int n_compared = 0;
    int cnt;

    ////////////////////////////////////////////////////////////////////////
    reset_strap_capture reset_strap_capture_inst (
        .CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WR_DATA_I(wdata),
        .WR_EN_I(wr_en), .RD_EN_I(rd_en), .RD_DATA_O(rd_data), .IRQ_O(irq),
        .LOOP_DIVIDER_STRAP_I(divider), .BYPASS_STRAP_I(bypass),
        .DEBUG_ENABLE_STRAP_N_I(debug_n), .CONFIG_STRAP_I(cfg),
        .LOOP_DIVIDER_O(div_out), .BYPASS_O(byp_out),
        .BOOT_CONFIG_O(boot_cfg), .BREAK_REQUEST_N_I(brk_n),
        .DEBUG_EVENT_I(dbg_event), .NMI_N_I(nmi_n),
        .ON_CHIP_DEBUG_SUPPORT_O(on_chip_debug_support), .HALT_REQ_O(halt),
        .BREAK_INDICATION_N_O(brk_ind_n), .NMI_TRAP_O(nmi_trap),
        .TEST_RESET_N_I(test_rst_n), .SCAN_RESET_N_O(scan_rst_n),
        .SCAN_ENABLE_O(scan_en), .WATCHDOG_RESET_I(wd),
        .WAKEUP_RESET_I(wake), .SW_RESET_I(sw),
        .HARDWARE_RESET_LINE_N_I(line_n), .HARDWARE_RESET_LINE_N_O(line_drv),
        .HARDWARE_RESET_LINE_N_OE_O(oe), .CHIP_RESET_O(chip_rst)
    );

    board_reset_model board_reset_model_inst (
        .clk_i(clk), .pull_req_i(pull), .line_oe_i(oe),
        .line_drive_i(line_drv), .divider_i(divider),
        .bypass_i(bypass_req), .bypass_o(bypass), .line_n_o(line_n)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Settle one ns past the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    task automatic evt(input int k);
        @(posedge clk);
        wd <= (k == 0);
        wake <= (k == 1);
        sw <= (k == 2);
        @(posedge clk);
        wd <= 1'b0;
        wake <= 1'b0;
        sw <= 1'b0;
    endtask

    // Bounded wait for the line pulse, then measure its exact length
    task automatic drive_len(input int exp);
        int n;
        int w;
        n = 0;
        w = 0;
        // Step off the edge so a pulse launched by it is already visible
        #1;
        while (oe !== 1'b1 && w < 20) begin
            cyc(1);
            w++;
        end
        while (oe === 1'b1 && n < 2000) begin
            if (n == 4) chk(32'(chip_rst), 32'h1);
            cyc(1);
            n++;
        end
        chk(n, exp);
        cyc(4);
        chk(32'(chip_rst), 32'h0);
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, wr_en, rd_en, addr, wdata, dbg_event, test_rst_n} = '0;
        {wd, wake, sw, pull, bypass_req, debug_n} = '0;
        {brk_n, nmi_n} = 2'h3;
        divider = 3'h5;
        cfg = 4'hA;
        cyc(2);
        chk(32'(chip_rst), 32'h1);
        @(posedge clk);
        resetn <= 1'b1;
        drive_len(`RSC_DRIVE_CYCLES);
        // New strap levels after release must not reach the captures
        @(posedge clk);
        divider <= 3'h2;
        bypass_req <= 1'b1;
        debug_n <= 1'b1;
        cfg <= 4'h3;
        cyc(3);
        chk(32'(div_out), 32'h5);
        chk(32'(byp_out), 32'h0);
        chk(32'(on_chip_debug_support), 32'h1);
        chk(32'(boot_cfg), 32'h2A);
        rd(`RSC_ADDR_CLK_CTRL, 32'h5);
        rd(`RSC_ADDR_STRAPS, 32'h2A);
        wr(`RSC_ADDR_CLK_CTRL, 32'hF);
        rd(`RSC_ADDR_CLK_CTRL, 32'h5);
        rd(8'h20, 32'h0);
        // Scan gating, break and debug event pins
        chk(32'(scan_en), 32'h0);
        @(posedge clk);
        test_rst_n <= 1'b1;
        brk_n <= 1'b0;
        dbg_event <= 1'b1;
        cyc(2);
        chk(32'({scan_en, scan_rst_n}), 32'h3);
        chk(32'(halt), 32'h1);
        chk(32'(brk_ind_n), 32'h0);
        @(posedge clk);
        brk_n <= 1'b1;
        dbg_event <= 1'b0;
        cyc(2);
        chk(32'({halt, brk_ind_n}), 32'h1);
        // One trap per falling edge, interrupt masked then enabled
        chk(32'(irq), 32'h0);
        wr(`RSC_ADDR_IRQ_ENABLE, 32'h1);
        @(posedge clk);
        nmi_n <= 1'b0;
        cnt = 0;
        repeat (8) begin
            cyc(1);
            if (nmi_trap === 1'b1) cnt++;
        end
        chk(cnt, 1);
        chk(32'(irq), 32'h1);
        rd(`RSC_ADDR_IRQ_STATUS, 32'h3);
        wr(`RSC_ADDR_IRQ_CLEAR, 32'hF);
        rd(`RSC_ADDR_IRQ_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        nmi_n <= 1'b1;
        // Software reset leaves the line alone until enabled
        evt(2);
        cyc(4);
        chk(32'(oe), 32'h0);
        wr(`RSC_ADDR_CONTROL, 32'h1);
        rd(`RSC_ADDR_CONTROL, 32'h1);
        evt(2);
        drive_len(`RSC_DRIVE_CYCLES);
        for (int k = 0; k < 2; k++) begin
            evt(k);
            drive_len(`RSC_DRIVE_CYCLES);
        end
        // External pull while idle
        @(posedge clk);
        pull <= 1'b1;
        @(posedge clk);
        pull <= 1'b0;
        drive_len(`RSC_DRIVE_CYCLES);
        rd(`RSC_ADDR_IRQ_STATUS, 32'h4);
        // Second power-on with new straps
        @(posedge clk);
        resetn <= 1'b0;
        brk_n <= 1'b0;
        cyc(1);
        chk(32'({chip_rst, oe}), 32'h2);
        @(posedge clk);
        resetn <= 1'b1;
        drive_len(`RSC_DRIVE_CYCLES);
        @(posedge clk);
        brk_n <= 1'b1;
        cyc(2);
        chk(32'({byp_out, div_out}), 32'hA);
        chk(32'(on_chip_debug_support), 32'h0);
        chk(32'(boot_cfg), 32'h13);
        rd(`RSC_ADDR_CLK_CTRL, 32'hA);
        conclude();
    end

    // Hang guard: far beyond the few thousand cycles the sequence needs
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule
